// ---- verilog/abe_pkg.sv ----
// Purpose: shared constants and types of the execution unit
// Assumes: 8-bit data path, 16-bit program counter
// Notes: flag bit positions follow the flag_register layout
package abe_pkg;
   // =========================================================
   // widths
   localparam int ABE_DW = 8;
   localparam int ABE_AW = 16;
   localparam int ABE_KW = 12;
   // =========================================================
   // flag_register bit positions
   localparam int FLG_C = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_N = 2;
   localparam int FLG_V = 3;
   localparam int FLG_S = 4;
   localparam int FLG_H = 5;
   localparam int FLG_T = 6;
   localparam int FLG_I = 7;
   localparam logic [7:0] ABE_FLAG_REGISTER_RST = 8'h00;
   localparam logic [7:0] ABE_ONES = 8'hFF;
   localparam logic [7:0] ABE_ZERO = 8'h00;
   localparam logic [7:0] ABE_MIN_NEG = 8'h80;
   localparam logic [7:0] ABE_MAX_POS = 8'h7F;
   // =========================================================
   // cycle counts
   localparam logic [2:0] CYC_ONE = 3'h1;
   localparam logic [2:0] CYC_TWO = 3'h2;
   localparam logic [2:0] CYC_THREE = 3'h3;
   localparam logic [2:0] CYC_FOUR = 3'h4;
   localparam logic [15:0] PC_STEP_ONE = 16'h0001;
   localparam logic [15:0] PC_STEP_TWO = 16'h0002;
   localparam logic [15:0] PC_STEP_THREE = 16'h0003;
   // =========================================================
   // operations
   typedef enum logic [5:0] {
      OP_ADD = 6'h00, OP_ADC = 6'h01, OP_WADD = 6'h02, OP_WSUB = 6'h03,
      OP_SUB = 6'h04, OP_MINUS_IMM = 6'h05, OP_SBC = 6'h06, OP_MINUS_IMM_CARRY = 6'h07,
      OP_AND = 6'h08, OP_ANDI = 6'h09, OP_OR = 6'h0A, OP_ORI = 6'h0B,
      OP_XOR = 6'h0C, OP_INV = 6'h0D, OP_NEG = 6'h0E, OP_SETB = 6'h0F,
      OP_CLRB = 6'h10, OP_INC = 6'h11, OP_DEC = 6'h12, OP_TST = 6'h13,
      OP_ZERO = 6'h14, OP_FILL = 6'h15, OP_MULU = 6'h16, OP_PRODUCT_SIGNED = 6'h17,
      OP_PRODUCT_MIXED = 6'h18, OP_FMULU = 6'h19, OP_FRAC_PRODUCT_SIGNED = 6'h1A, OP_FRAC_PRODUCT_MIXED = 6'h1B,
      OP_REL_JUMP = 6'h1C, OP_ZJMP = 6'h1D, OP_REL_CALL = 6'h1E, OP_ZCALL = 6'h1F,
      OP_RET = 6'h20, OP_BACK_FROM_IRQ = 6'h21, OP_SKEQ = 6'h22, OP_CMP = 6'h23,
      OP_CMPC = 6'h24, OP_CMPI = 6'h25, OP_SKRC = 6'h26, OP_SKRS = 6'h27,
      OP_SKIC = 6'h28, OP_SKIS = 6'h29, OP_BRS = 6'h2A, OP_BRC = 6'h2B,
      OP_BRANCH_ON_ZERO = 6'h2C
   } abe_op_e;
   // =========================================================
   // sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_WAIT = 2'b10
   } abe_state_e;
endpackage

// ---- verilog/abe_mult.sv ----
// Purpose: 8x8 multiplier with signed, mixed and fractional forms
// Assumes: combinational, result sampled by the execution unit
// Notes: carry is product bit 15 before the fractional shift
`timescale 1ns/1ns
module abe_mult
   import abe_pkg::*;
(
   input wire logic [7:0] i_a,
   input wire logic [7:0] i_b,
   input wire logic i_a_signed,
   input wire logic i_b_signed,
   input wire logic i_frac,
   output logic [15:0] o_prod,
   output logic o_carry
);
   logic signed [17:0] full;
   logic [15:0] raw;
   always_comb
   begin
      full = $signed({i_a_signed & i_a[7], i_a}) * $signed({i_b_signed & i_b[7], i_b});
      raw = full[15:0];
      o_carry = raw[15];
      o_prod = i_frac ? {raw[14:0], 1'b0} : raw;
   end
endmodule // abe_mult

// ---- verilog/abe_exec.sv ----
// Purpose: execution unit for arithmetic, logic, multiply and branch operations
// Assumes: decoder gives one operation per i_start pulse with its operands
// Notes: results and flags appear with o_done after the operation's cycle count
`timescale 1ns/1ns
module abe_exec
   import abe_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_start,
   input wire abe_op_e i_op,
   input wire logic [7:0] i_rd,
   input wire logic [7:0] i_rr,
   input wire logic [7:0] i_imm,
   input wire logic [15:0] i_word,
   input wire logic [15:0] i_zptr,
   input wire logic [15:0] i_pc,
   input wire logic [15:0] i_stack_pc,
   input wire logic [11:0] i_offset,
   input wire logic [2:0] i_bit_sel,
   input wire logic i_io_bit,
   input wire logic i_next_two_word,
   input wire logic i_flag_load,
   input wire logic [7:0] i_flag_data,
   output logic o_busy,
   output logic o_done,
   output logic o_rd_we,
   output logic [7:0] o_rd_data,
   output logic o_word_we,
   output logic [15:0] o_word_data,
   output logic o_prod_we,
   output logic [15:0] o_prod_data,
   output logic o_pc_we,
   output logic [15:0] o_pc_data,
   output logic o_push_we,
   output logic [15:0] o_push_data,
   output logic [7:0] o_flags
);
   // =========================================================
   // state
   typedef struct packed {
      abe_state_e st;
      logic [2:0] cnt;
      logic busy;
      logic done;
      logic p_rd, p_word, p_prod, p_pc, p_push;
      logic rd_we, word_we, prod_we, pc_we, push_we;
      logic [7:0] rd_data;
      logic [15:0] word_data;
      logic [15:0] prod_data;
      logic [15:0] pc_data;
      logic [15:0] push_data;
      logic [7:0] flags;
      logic [7:0] p_flags;
   } abe_regs_s;
   abe_regs_s s_r;
   abe_regs_s s_nxt;
   // =========================================================
   // helpers: {h, v, c, result}
   function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
                                        input logic ci);
      logic [8:0] t;
      logic h, v;
      t = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      h = (a[3] & b[3]) | (b[3] & ~t[3]) | (~t[3] & a[3]);
      v = (a[7] & b[7] & ~t[7]) | (~a[7] & ~b[7] & t[7]);
      return {h, v, t[8], t[7:0]};
   endfunction
   function automatic logic [10:0] sub8(input logic [7:0] a, input logic [7:0] b,
                                        input logic ci);
      logic [8:0] t;
      logic h, v;
      t = {1'b0, a} - {1'b0, b} - {8'h00, ci};
      h = (~a[3] & b[3]) | (b[3] & t[3]) | (t[3] & ~a[3]);
      v = (a[7] & ~b[7] & ~t[7]) | (~a[7] & b[7] & t[7]);
      return {h, v, t[8], t[7:0]};
   endfunction
   // =========================================================
   // multiplier
   logic m_as, m_bs, m_frac, m_c;
   logic [15:0] m_prod;
   always_comb
   begin
      m_as = i_op inside {OP_PRODUCT_SIGNED, OP_PRODUCT_MIXED, OP_FRAC_PRODUCT_SIGNED, OP_FRAC_PRODUCT_MIXED};
      m_bs = i_op inside {OP_PRODUCT_SIGNED, OP_FRAC_PRODUCT_SIGNED};
      m_frac = i_op inside {OP_FMULU, OP_FRAC_PRODUCT_SIGNED, OP_FRAC_PRODUCT_MIXED};
   end
   abe_mult abe_mult_inst (
      .i_a(i_rd),
      .i_b(i_rr),
      .i_a_signed(m_as),
      .i_b_signed(m_bs),
      .i_frac(m_frac),
      .o_prod(m_prod),
      .o_carry(m_c)
   );
   // =========================================================
   // operation decode
   logic [10:0] ar;
   logic [16:0] wr;
   logic [7:0] f, res;
   logic [2:0] cyc;
   logic w_rd, w_word, w_prod, w_pc, w_push, skip, br_take;
   logic [15:0] pc_new, rel_tgt, seq_pc;
   always_comb
   begin
      f = s_r.flags;
      ar = 11'h000;
      wr = 17'h00000;
      res = ABE_ZERO;
      cyc = CYC_ONE;
      w_rd = 1'b0;
      w_word = 1'b0;
      w_prod = 1'b0;
      w_pc = 1'b0;
      w_push = 1'b0;
      skip = 1'b0;
      br_take = 1'b0;
      rel_tgt = i_pc + {{4{i_offset[11]}}, i_offset} + PC_STEP_ONE;
      seq_pc = i_pc + PC_STEP_ONE;
      pc_new = seq_pc;
      case (i_op)
         OP_ADD, OP_ADC:
         begin
            ar = add8(i_rd, i_rr, (i_op == OP_ADC) & s_r.flags[FLG_C]);
            w_rd = 1'b1;
         end
         OP_SUB, OP_MINUS_IMM, OP_SBC, OP_MINUS_IMM_CARRY, OP_CMP, OP_CMPC, OP_CMPI:
         begin
            ar = sub8(i_rd, (i_op inside {OP_MINUS_IMM, OP_MINUS_IMM_CARRY, OP_CMPI}) ? i_imm : i_rr,
                      (i_op inside {OP_SBC, OP_MINUS_IMM_CARRY, OP_CMPC}) & s_r.flags[FLG_C]);
            w_rd = !(i_op inside {OP_CMP, OP_CMPC, OP_CMPI});
         end
         OP_NEG:
         begin
            ar = sub8(ABE_ZERO, i_rd, 1'b0);
            w_rd = 1'b1;
         end
         default:
         begin
            ar = 11'h000;
         end
      endcase
      res = ar[7:0];
      case (i_op)
         OP_ADD, OP_ADC, OP_SUB, OP_MINUS_IMM, OP_SBC, OP_MINUS_IMM_CARRY, OP_CMP, OP_CMPC, OP_CMPI,
         OP_NEG:
         begin
            f[FLG_H] = ar[10];
            f[FLG_V] = ar[9];
            f[FLG_C] = ar[8];
            f[FLG_N] = res[7];
            // borrow forms keep zero only if it was already set
            f[FLG_Z] = (res == ABE_ZERO) &
                       (!(i_op inside {OP_SBC, OP_MINUS_IMM_CARRY, OP_CMPC}) | s_r.flags[FLG_Z]);
         end
         OP_WADD, OP_WSUB:
         begin
            wr = (i_op == OP_WADD) ? {1'b0, i_word} + {9'h000, i_imm}
                                   : {1'b0, i_word} - {9'h000, i_imm};
            cyc = CYC_TWO;
            w_word = 1'b1;
            f[FLG_Z] = (wr[15:0] == 16'h0000);
            f[FLG_N] = wr[15];
            f[FLG_C] = wr[16];
            f[FLG_V] = (i_op == OP_WADD) ? (~i_word[15] & wr[15]) : (i_word[15] & ~wr[15]);
            f[FLG_S] = wr[15] ^ f[FLG_V];
         end
         OP_AND, OP_ANDI, OP_OR, OP_ORI, OP_XOR, OP_SETB, OP_CLRB, OP_TST, OP_ZERO,
         OP_INC, OP_DEC, OP_INV:
         begin
            case (i_op)
               OP_AND: res = i_rd & i_rr;
               OP_ANDI: res = i_rd & i_imm;
               OP_OR: res = i_rd | i_rr;
               OP_ORI, OP_SETB: res = i_rd | i_imm;
               OP_XOR: res = i_rd ^ i_rr;
               OP_CLRB: res = i_rd & (ABE_ONES - i_imm);
               OP_TST: res = i_rd & i_rd;
               OP_ZERO: res = i_rd ^ i_rd;
               OP_INC: res = i_rd + 8'h01;
               OP_DEC: res = i_rd - 8'h01;
               default: res = ABE_ONES - i_rd;
            endcase
            w_rd = (i_op != OP_TST);
            f[FLG_Z] = (res == ABE_ZERO);
            f[FLG_N] = res[7];
            f[FLG_V] = (i_op == OP_INC) ? (res == ABE_MIN_NEG) :
                       (i_op == OP_DEC) ? (res == ABE_MAX_POS) : 1'b0;
            if (i_op == OP_INV)
               f[FLG_C] = 1'b1;
         end
         OP_FILL:
         begin
            res = ABE_ONES;
            w_rd = 1'b1;
         end
         OP_MULU, OP_PRODUCT_SIGNED, OP_PRODUCT_MIXED, OP_FMULU, OP_FRAC_PRODUCT_SIGNED, OP_FRAC_PRODUCT_MIXED:
         begin
            cyc = CYC_TWO;
            w_prod = 1'b1;
            f[FLG_Z] = (m_prod == 16'h0000);
            f[FLG_C] = m_c;
         end
         OP_REL_JUMP, OP_REL_CALL:
         begin
            pc_new = rel_tgt;
            cyc = (i_op == OP_REL_CALL) ? CYC_THREE : CYC_TWO;
            w_pc = 1'b1;
            w_push = (i_op == OP_REL_CALL);
         end
         OP_ZJMP, OP_ZCALL:
         begin
            pc_new = i_zptr;
            cyc = (i_op == OP_ZCALL) ? CYC_THREE : CYC_TWO;
            w_pc = 1'b1;
            w_push = (i_op == OP_ZCALL);
         end
         OP_RET, OP_BACK_FROM_IRQ:
         begin
            pc_new = i_stack_pc;
            cyc = CYC_FOUR;
            w_pc = 1'b1;
            if (i_op == OP_BACK_FROM_IRQ)
               f[FLG_I] = 1'b1;
         end
         OP_SKEQ, OP_SKRC, OP_SKRS, OP_SKIC, OP_SKIS:
         begin
            case (i_op)
               OP_SKEQ: skip = (i_rd == i_rr);
               OP_SKRC: skip = !i_rr[i_bit_sel];
               OP_SKRS: skip = i_rr[i_bit_sel];
               OP_SKIC: skip = !i_io_bit;
               default: skip = i_io_bit;
            endcase
            w_pc = 1'b1;
            if (skip)
            begin
               cyc = i_next_two_word ? CYC_THREE : CYC_TWO;
               pc_new = i_pc + (i_next_two_word ? PC_STEP_THREE : PC_STEP_TWO);
            end
         end
         OP_BRS, OP_BRC, OP_BRANCH_ON_ZERO:
         begin
            br_take = (i_op == OP_BRANCH_ON_ZERO) ? s_r.flags[FLG_Z] :
                      (s_r.flags[i_bit_sel] == (i_op == OP_BRS));
            w_pc = 1'b1;
            if (br_take)
            begin
               cyc = CYC_TWO;
               pc_new = rel_tgt;
            end
         end
         default:
         begin
            cyc = CYC_ONE;
         end
      endcase
   end
   // =========================================================
   // sequencer
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      s_nxt.rd_we = 1'b0;
      s_nxt.word_we = 1'b0;
      s_nxt.prod_we = 1'b0;
      s_nxt.pc_we = 1'b0;
      s_nxt.push_we = 1'b0;
      case (s_r.st)
         ST_IDLE:
         begin
            if (i_flag_load)
               s_nxt.flags = i_flag_data;
            if (i_start)
            begin
               s_nxt.rd_data = res;
               s_nxt.word_data = wr[15:0];
               s_nxt.prod_data = m_prod;
               s_nxt.pc_data = pc_new;
               s_nxt.push_data = seq_pc;
               s_nxt.p_rd = w_rd;
               s_nxt.p_word = w_word;
               s_nxt.p_prod = w_prod;
               s_nxt.p_pc = w_pc;
               s_nxt.p_push = w_push;
               s_nxt.p_flags = f;
               if (cyc == CYC_ONE)
               begin
                  s_nxt.done = 1'b1;
                  s_nxt.rd_we = w_rd;
                  s_nxt.pc_we = w_pc;
                  s_nxt.flags = f;
               end
               else
               begin
                  s_nxt.busy = 1'b1;
                  s_nxt.cnt = cyc - CYC_ONE;
                  s_nxt.st = ST_WAIT;
               end
            end
         end
         ST_WAIT:
         begin
            if (s_r.cnt == CYC_ONE)
            begin
               s_nxt.done = 1'b1;
               s_nxt.busy = 1'b0;
               s_nxt.rd_we = s_r.p_rd;
               s_nxt.word_we = s_r.p_word;
               s_nxt.prod_we = s_r.p_prod;
               s_nxt.pc_we = s_r.p_pc;
               s_nxt.push_we = s_r.p_push;
               s_nxt.flags = s_r.p_flags;
               s_nxt.st = ST_IDLE;
            end
            else
               s_nxt.cnt = s_r.cnt - CYC_ONE;
         end
         default:
         begin
            s_nxt.st = ST_IDLE;
            s_nxt.busy = 1'b0;
         end
      endcase
   end
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         s_r <= '0;
         s_r.st <= ST_IDLE;
         s_r.flags <= ABE_FLAG_REGISTER_RST;
      end
      else
         s_r <= s_nxt;
   end
   // =========================================================
   // outputs
   assign o_busy = s_r.busy;
   assign o_done = s_r.done;
   assign o_rd_we = s_r.rd_we;
   assign o_rd_data = s_r.rd_data;
   assign o_word_we = s_r.word_we;
   assign o_word_data = s_r.word_data;
   assign o_prod_we = s_r.prod_we;
   assign o_prod_data = s_r.prod_data;
   assign o_pc_we = s_r.pc_we;
   assign o_pc_data = s_r.pc_data;
   assign o_push_we = s_r.push_we;
   assign o_push_data = s_r.push_data;
   assign o_flags = s_r.flags;
endmodule // abe_exec

// ---- verif/abe_exec_checker.sv ----
// Purpose: concurrent checks on the execution unit ports
// Assumes: one clock domain, asynchronous active-low reset
// Notes: attached to every abe_exec by the bind below
`timescale 1ns/1ns
module abe_exec_checker
   import abe_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_start,
   input wire abe_op_e i_op,
   input wire logic [7:0] i_rd,
   input wire logic [7:0] i_rr,
   input wire logic [15:0] i_zptr,
   input wire logic [15:0] i_pc,
   input wire logic [15:0] i_stack_pc,
   input wire logic o_busy,
   input wire logic o_done,
   input wire logic o_rd_we,
   input wire logic [7:0] o_rd_data,
   input wire logic o_prod_we,
   input wire logic o_pc_we,
   input wire logic [15:0] o_pc_data,
   input wire logic [15:0] o_push_data,
   input wire logic [7:0] o_flags
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   // =========================================================
   // sequences
   sequence s_take(abe_op_e op);
      i_start && !o_busy && i_op == op;
   endsequence
   sequence s_wait3;
      (o_busy && !o_done)[*3];
   endsequence
   // =========================================================
   // properties
   AST_ADD_ONE: assert property (s_take(OP_ADD) |=> o_done && o_rd_we && !o_busy)
      else $error("add not done in one cycle");
   AST_MUL_TWO: assert property (s_take(OP_MULU) |=> o_busy && !o_done
      ##1 o_done && o_prod_we) else $error("multiply not done in two cycles");
   AST_RET_FOUR: assert property (s_take(OP_RET) |=> s_wait3 ##1 o_done && o_pc_we
      && o_pc_data == $past(i_stack_pc, 4)) else $error("return timing or target wrong");
   AST_CALL_PUSH: assert property (s_take(OP_REL_CALL) |=> !o_done ##1 !o_done
      ##1 o_done && o_push_data == $past(i_pc, 3) + 16'h0001)
      else $error("call timing or push wrong");
   AST_ZJMP_TWO: assert property (s_take(OP_ZJMP) |=> ##1 o_done && o_pc_we
      && o_pc_data == $past(i_zptr, 2)) else $error("pointer jump wrong");
   AST_FILL_KEEP: assert property (s_take(OP_FILL) |=> o_rd_data == 8'hFF
      && o_flags == $past(o_flags)) else $error("fill changed flags or value");
   AST_CMP_NOWR: assert property (s_take(OP_CMP) |=> o_done && !o_rd_we)
      else $error("compare wrote a register");
   AST_BRANCH_ON_ZERO_NT: assert property (s_take(OP_BRANCH_ON_ZERO) ##0 !o_flags[FLG_Z] |=> o_done
      && o_pc_data == $past(i_pc) + 16'h0001) else $error("untaken branch wrong");
   AST_SKEQ_NE: assert property (s_take(OP_SKEQ) ##0 i_rd != i_rr |=> o_done
      && o_pc_data == $past(i_pc) + 16'h0001) else $error("unequal skip wrong");
endmodule // abe_exec_checker
bind abe_exec abe_exec_checker abe_exec_checker_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
   .i_start(i_start), .i_op(i_op), .i_rd(i_rd), .i_rr(i_rr), .i_zptr(i_zptr), .i_pc(i_pc),
   .i_stack_pc(i_stack_pc), .o_busy(o_busy), .o_done(o_done), .o_rd_we(o_rd_we),
   .o_rd_data(o_rd_data), .o_prod_we(o_prod_we), .o_pc_we(o_pc_we), .o_pc_data(o_pc_data),
   .o_push_data(o_push_data), .o_flags(o_flags));

// ---- verif/test_alu_and_branch_execution.sv ----
// Purpose: self-checking bench of the execution unit
// Assumes: inputs driven 1 ns after the rising edge
// Notes: expected values worked out by hand from the operation table
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module test_alu_and_branch_execution;
   import abe_pkg::*;
   logic i_mclk = 0, i_rst_n = 0, i_start = 0, i_io_bit = 0, i_next_two_word = 0;
   logic i_flag_load = 0;
   abe_op_e i_op = OP_ADD;
   logic [7:0] i_rd = 8'h00, i_rr = 8'h00, i_imm = 8'h00, i_flag_data = 8'h00;
   logic [15:0] i_word = 16'h0000, i_zptr = 16'h1234, i_pc = 16'h0100, i_stack_pc = 16'h0ABC;
   logic [11:0] i_offset = 12'hFFE;
   logic [2:0] i_bit_sel = 3'h3;
   logic o_busy, o_done, o_rd_we, o_word_we, o_prod_we, o_pc_we, o_push_we;
   logic [7:0] o_rd_data, o_flags;
   logic [15:0] o_word_data, o_prod_data, o_pc_data, o_push_data;
   int n_mismatch = 0;
   int n_compared = 0;
   always #2 i_mclk = ~i_mclk;
   abe_exec abe_exec_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_start(i_start), .i_op(i_op),
      .i_rd(i_rd), .i_rr(i_rr), .i_imm(i_imm), .i_word(i_word), .i_zptr(i_zptr), .i_pc(i_pc),
      .i_stack_pc(i_stack_pc), .i_offset(i_offset), .i_bit_sel(i_bit_sel),
      .i_io_bit(i_io_bit), .i_next_two_word(i_next_two_word), .i_flag_load(i_flag_load),
      .i_flag_data(i_flag_data), .o_busy(o_busy), .o_done(o_done), .o_rd_we(o_rd_we),
      .o_rd_data(o_rd_data), .o_word_we(o_word_we), .o_word_data(o_word_data),
      .o_prod_we(o_prod_we), .o_prod_data(o_prod_data), .o_pc_we(o_pc_we),
      .o_pc_data(o_pc_data), .o_push_we(o_push_we), .o_push_data(o_push_data),
      .o_flags(o_flags));
   // =========================================================
   // helpers
   task automatic stop_test;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
      begin
         $display("bench passed");
      end
      else
      begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic ldf(input logic [7:0] v);
      i_flag_load = 1;
      i_flag_data = v;
      @(posedge i_mclk);
      #1 i_flag_load = 0;
      `CHK("flag load", v, o_flags)
   endtask
   // one operation: operands, start pulse, bounded wait, cycle count
   task automatic go(input abe_op_e op, input logic [7:0] d, input logic [7:0] r, input int cyc);
      int n;
      i_op = op;
      i_rd = d;
      i_rr = r;
      i_imm = r;
      i_start = 1;
      @(posedge i_mclk);
      #1 i_start = 0;
      n = 1;
      while (o_done !== 1'b1 && n < 8)
      begin
         @(posedge i_mclk);
         #1 n++;
      end
      `CHK("cycles", cyc, n)
   endtask
   // =========================================================
   // scenarios
   task automatic t_add;
      ldf(8'h50);
      go(OP_ADD, 8'h0F, 8'h01, 1);
      `CHK("add data", 8'h10, o_rd_data)
      `CHK("add flags", 8'h70, o_flags)
      ldf(8'h01);
      go(OP_ADC, 8'h7F, 8'h00, 1);
      `CHK("adc data", 8'h80, o_rd_data)
      `CHK("adc flags", 8'h2C, o_flags)
   endtask
   task automatic t_word;
      i_word = 16'hFFFF;
      go(OP_WADD, 8'h00, 8'h01, 2);
      `CHK("wadd we", 1'b1, o_word_we)
      `CHK("wadd data", 16'h0000, o_word_data)
      `CHK("wadd flags", 8'h23, o_flags)
      i_word = 16'h8000;
      go(OP_WSUB, 8'h00, 8'h01, 2);
      `CHK("wsub data", 16'h7FFF, o_word_data)
      `CHK("wsub flags", 8'h38, o_flags)
   endtask
   task automatic t_sub;
      ldf(8'h03);
      go(OP_SBC, 8'h01, 8'h00, 1);
      `CHK("sbc data", 8'h00, o_rd_data)
      `CHK("sbc flags", 8'h02, o_flags)
      go(OP_MINUS_IMM, 8'h10, 8'h01, 1);
      `CHK("minus_imm data", 8'h0F, o_rd_data)
      `CHK("minus_imm flags", 8'h20, o_flags)
   endtask
   task automatic t_logic;
      ldf(8'h21);
      go(OP_AND, 8'h80, 8'hC0, 1);
      `CHK("and data", 8'h80, o_rd_data)
      `CHK("and flags", 8'h25, o_flags)
      go(OP_CLRB, 8'hFF, 8'h0F, 1);
      `CHK("clear mask", 8'hF0, o_rd_data)
      go(OP_FILL, 8'h12, 8'h00, 1);
      `CHK("fill data", 8'hFF, o_rd_data)
      `CHK("fill flags", 8'h25, o_flags)
   endtask
   task automatic t_mul;
      ldf(8'h02);
      go(OP_PRODUCT_SIGNED, 8'hFF, 8'h02, 2);
      `CHK("product_signed prod", 16'hFFFE, o_prod_data)
      `CHK("product_signed flags", 8'h01, o_flags)
      go(OP_MULU, 8'h00, 8'h33, 2);
      `CHK("mulu flags", 8'h02, o_flags)
      go(OP_FMULU, 8'h80, 8'h80, 2);
      `CHK("frac_product_unsigned prod", 16'h8000, o_prod_data)
      `CHK("frac_product_unsigned flags", 8'h00, o_flags)
   endtask
   task automatic t_flow;
      go(OP_REL_JUMP, 8'h00, 8'h00, 2);
      `CHK("rel_jump pc", 16'h00FF, o_pc_data)
      go(OP_REL_CALL, 8'h00, 8'h00, 3);
      `CHK("rel_call push", 16'h0101, o_push_data)
      `CHK("rel_call push we", 1'b1, o_push_we)
      go(OP_ZCALL, 8'h00, 8'h00, 3);
      `CHK("zcall pc", 16'h1234, o_pc_data)
      go(OP_ZJMP, 8'h00, 8'h00, 2);
      go(OP_RET, 8'h00, 8'h00, 4);
      `CHK("ret pc", 16'h0ABC, o_pc_data)
      go(OP_BACK_FROM_IRQ, 8'h00, 8'h00, 4);
      `CHK("back_from_irq flag", 1'b1, o_flags[FLG_I])
   endtask
   task automatic t_skip;
      i_next_two_word = 1;
      go(OP_SKEQ, 8'h55, 8'h55, 3);
      `CHK("skip eq pc", 16'h0103, o_pc_data)
      go(OP_SKEQ, 8'h55, 8'h54, 1);
      i_next_two_word = 0;
      go(OP_SKRS, 8'h00, 8'h08, 2);
      `CHK("skip set pc", 16'h0102, o_pc_data)
      go(OP_SKRC, 8'h00, 8'h08, 1);
      i_io_bit = 1;
      go(OP_SKIC, 8'h00, 8'h00, 1);
      `CHK("io clear pc", 16'h0101, o_pc_data)
      go(OP_SKIS, 8'h00, 8'h00, 2);
   endtask
   task automatic t_branch;
      ldf(8'h40);
      i_bit_sel = 3'h6;
      i_offset = 12'h010;
      go(OP_BRS, 8'h00, 8'h00, 2);
      `CHK("taken pc", 16'h0111, o_pc_data)
      go(OP_BRC, 8'h00, 8'h00, 1);
      `CHK("untaken pc", 16'h0101, o_pc_data)
      go(OP_BRANCH_ON_ZERO, 8'h00, 8'h00, 1);
      `CHK("branch flags", 8'h40, o_flags)
   endtask
   task automatic t_cmp;
      ldf(8'h00);
      go(OP_CMP, 8'h10, 8'h20, 1);
      `CHK("cmp we", 1'b0, o_rd_we)
      `CHK("cmp flags", 8'h05, o_flags)
      go(OP_CMPI, 8'h10, 8'h10, 1);
      `CHK("cmpi flags", 8'h02, o_flags)
   endtask
   task automatic t_unary;
      ldf(8'h00);
      go(OP_INC, 8'h7F, 8'h00, 1);
      `CHK("inc flags", 8'h0C, o_flags)
      go(OP_DEC, 8'h80, 8'h00, 1);
      `CHK("dec data", 8'h7F, o_rd_data)
      `CHK("dec flags", 8'h08, o_flags)
      go(OP_TST, 8'h00, 8'h00, 1);
      `CHK("probe we", 1'b0, o_rd_we)
      `CHK("probe flags", 8'h02, o_flags)
      go(OP_ZERO, 8'h5A, 8'h00, 1);
      `CHK("zero we", 1'b1, o_rd_we)
      `CHK("zero data", 8'h00, o_rd_data)
      go(OP_INV, 8'h0F, 8'h00, 1);
      `CHK("invert data", 8'hF0, o_rd_data)
      `CHK("invert flags", 8'h05, o_flags)
      go(OP_NEG, 8'h01, 8'h00, 1);
      `CHK("negate data", 8'hFF, o_rd_data)
      `CHK("negate flags", 8'h25, o_flags)
      go(OP_XOR, 8'hF0, 8'hFF, 1);
      `CHK("xor data", 8'h0F, o_rd_data)
      `CHK("xor flags", 8'h21, o_flags)
      go(OP_SETB, 8'h01, 8'h80, 1);
      `CHK("set mask", 8'h81, o_rd_data)
   endtask
   // =========================================================
   // main sequence and watchdog
   initial
   begin
      repeat (20) @(posedge i_mclk);
      #1 i_rst_n = 1;
      `CHK("reset flags", 8'h00, o_flags)
      t_add();
      t_word();
      t_sub();
      t_logic();
      t_mul();
      t_flow();
      t_skip();
      t_branch();
      t_cmp();
      t_unary();
      stop_test();
   end
   initial
   begin
      #40000 n_mismatch++;
      stop_test();
   end
endmodule // test_alu_and_branch_execution
